// file: ssm_drive_model.sv
/*
  Behavioural spindle drive and encoder facing ssm_top.
  Assumes the bench raises req_i bits for one cycle to ask for pin pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_drive_model (
  input  wire logic           mclk_i,
  input  wire logic           rst_b_i,
  input  wire logic [23:0]    spd_cmd_i,
  input  wire logic [23:0]    spd_err_i,
  input  wire logic [1:0]     prog_i,
  input  wire logic [5:0]     req_i,
  input  wire logic [1:0]     cut_i,
  output ssm_pkg::ssm_drive_s drv0_o,
  output ssm_pkg::ssm_drive_s drv1_o,
  output logic [23:0]         act_spd_o
);
  logic [2:0] hold_reg [6];
  // Six cycles high, so a 3-stage synchroniser cannot miss a pulse
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    for (int k = 0; k < 6; k++) begin
      if (!rst_b_i) begin
        hold_reg[k] <= 3'h0;
      end else if (req_i[k]) begin
        hold_reg[k] <= 3'h6;
      end else if (hold_reg[k] != 3'h0) begin
        hold_reg[k] <= hold_reg[k] - 3'h1;
      end
    end
  end
  // Speed follows the command a cycle late; err models a drive fault
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_spd_o <= 24'h0;
    end else begin
      act_spd_o <= spd_cmd_i + spd_err_i;
    end
  end
  // Encoder kept still: position never moves between captures
  assign drv0_o = {32'h0, |hold_reg[0], |hold_reg[2], prog_i[0], |hold_reg[4], cut_i[0]};
  assign drv1_o = {32'h0, |hold_reg[1], |hold_reg[3], prog_i[1], |hold_reg[5], cut_i[1]};
endmodule
`default_nettype wire

// file: ssm_pkg.sv
/*
  Shared constants and carrier types for the spindle synchronisation and
  monitoring block. Assumes a single 125 MHz clock domain.
*/
package ssm_pkg;

  localparam int POS_W = 32;
  localparam int SPD_W = 24;
  localparam int GEAR_W = 3;

  // Referencing source encodings
  localparam logic [1:0] SRC_ZERO_MARK = 2'h1;
  localparam logic [1:0] SRC_PROX_SW   = 2'h2;

  // Register offsets
  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_REF_POS  = 4'h1;
  localparam logic [3:0] A_ZM_OFS   = 4'h2;
  localparam logic [3:0] A_STOP_TOL = 4'h3;
  localparam logic [3:0] A_SET_TOL  = 4'h4;
  localparam logic [3:0] A_MAX_SPD  = 4'h5;
  localparam logic [3:0] A_STATUS   = 4'h6;
  localparam logic [3:0] A_IRQ_STAT = 4'h7;
  localparam logic [3:0] A_IRQ_EN   = 4'h8;
  localparam logic [3:0] A_IRQ_CLR  = 4'h9;
  localparam logic [3:0] A_POS0     = 4'hA;
  localparam logic [3:0] A_POS1     = 4'hB;
  localparam logic [3:0] A_CMD_SPD  = 4'hC;

  // Control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_DIRECT  = 2;
  localparam int CTRL_FEEDEN  = 3;
  localparam int CTRL_RESYNC0 = 4;
  localparam int CTRL_RESYNC1 = 5;

  // Interrupt event bits
  localparam int EV_SYNC0 = 0;
  localparam int EV_SYNC1 = 1;
  localparam int EV_LIMIT = 2;
  localparam int EV_W     = 3;

  // Alarm code raised on speed-limit violation
  localparam logic [15:0] ALARM_SPEED_LIMIT = 16'h5686;

  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // Inputs from one spindle drive/encoder
  typedef struct packed {
    logic [POS_W-1:0] enc_delta;
    logic             zero_mark;
    logic             prox_sw;
    logic             prog_cmd;
    logic             gear_change;
    logic             over_cutoff;
  } ssm_drive_s;

  typedef struct packed {
    logic stopped;
    logic in_setpoint;
    logic limit_exc;
  } ssm_mon_s;

endpackage

// file: ssm_speed_mon.sv
/*
  Speed monitor: clamps the command and compares actual speed with the
  standstill, setpoint and limit bands. Same clock domain as its user.
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_speed_mon #(
  parameter int SPD_W = ssm_pkg::SPD_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic [SPD_W-1:0] act_spd_i,
  input  wire logic [SPD_W-1:0] cmd_spd_i,
  input  wire logic [SPD_W-1:0] stop_tol_i,
  input  wire logic [SPD_W-1:0] set_tol_i,
  input  wire logic [SPD_W-1:0] max_spd_i,
  output logic [SPD_W-1:0]      clamp_spd_o,
  output ssm_pkg::ssm_mon_s     mon_o
);

  logic [SPD_W-1:0] lim;
  logic [SPD_W:0]   diff;
  logic [SPD_W:0]   lim_tol;

  // Clamp command first so the setpoint band uses the real target
  assign lim     = (cmd_spd_i > max_spd_i) ? max_spd_i : cmd_spd_i; // [R13]
  assign diff    = (act_spd_i > lim) ? {1'b0, act_spd_i - lim} : {1'b0, lim - act_spd_i};
  assign lim_tol = {1'b0, max_spd_i} + {1'b0, set_tol_i};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clamp_spd_o <= '0;
      mon_o       <= '0;
    end else begin
      clamp_spd_o       <= lim; // [R13]
      mon_o.stopped     <= act_spd_i < stop_tol_i; // [R10]
      mon_o.in_setpoint <= diff <= {1'b0, set_tol_i}; // [R12]
      mon_o.limit_exc   <= {1'b0, act_spd_i} > lim_tol; // [R14]
    end
  end

endmodule
`default_nettype wire

// file: ssm_spindle_sync.sv
/*
  Per-spindle synchronisation: tracks position and loads the reference value
  on the selected pulse. Assumes pulse inputs already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_spindle_sync #(
  parameter int POS_W = ssm_pkg::POS_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic [POS_W-1:0] enc_delta_i,
  input  wire logic             zero_mark_i,
  input  wire logic             prox_sw_i,
  input  wire logic             prog_cmd_i,
  input  wire logic             need_sync_i,
  input  wire logic [1:0]       src_sel_i,
  input  wire logic [POS_W-1:0] ref_pos_i,
  input  wire logic [POS_W-1:0] zm_ofs_i,
  output logic [POS_W-1:0]      pos_o,
  output logic                  synced_o,
  output logic                  sync_evt_o
);

  typedef enum logic [1:0] {SS_IDLE, SS_WAIT, SS_DONE} ssm_sync_e;
  ssm_sync_e state_reg;
  logic      pulse;
  logic      pulse_d_reg;
  logic      pulse_rise;

  // Source select: zero mark or proximity switch
  always_comb begin
    case (src_sel_i)
      ssm_pkg::SRC_PROX_SW: pulse = prox_sw_i; // [R3]
      default:              pulse = zero_mark_i; // [R3]
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_d_reg <= 1'b0;
    end else begin
      pulse_d_reg <= pulse;
    end
  end
  assign pulse_rise = pulse & ~pulse_d_reg;

  // Sync state; starts unsynchronised so first program move syncs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= SS_WAIT; // [R4]
    end else begin
      case (state_reg)
        SS_IDLE: state_reg <= SS_WAIT;
        SS_WAIT: if (pulse_rise && prog_cmd_i) state_reg <= SS_DONE; // [R8]
        SS_DONE: if (need_sync_i) state_reg <= SS_WAIT; // [R15]
        default: state_reg <= SS_WAIT;
      endcase
    end
  end

  // Position counter; reference capture overrides counting
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_o <= '0;
    end else if (state_reg == SS_WAIT && pulse_rise && prog_cmd_i) begin
      pos_o <= ref_pos_i + zm_ofs_i + enc_delta_i; // [R1] [R2]
    end else begin
      pos_o <= pos_o + enc_delta_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      synced_o   <= 1'b0;
      sync_evt_o <= 1'b0;
    end else begin
      synced_o   <= (state_reg == SS_DONE) && !need_sync_i; // [R15]
      sync_evt_o <= state_reg == SS_WAIT && pulse_rise && prog_cmd_i;
    end
  end

endmodule
`default_nettype wire

// file: ssm_top.sv
/*
  Spindle synchronisation and monitoring top: register port, two spindle
  sync engines, speed monitor, interrupt. Assumes one 125 MHz clock and
  drive/encoder pins asynchronous to it; encoder delta is clock-synchronous.
*/
// Design decisions made here: the address-and-strobe port and the placing of the registers.
// Summary of operation
// R1: Reference pulse loads configured reference position
// R2: Zero mark offset added on capture
// R3: Source 1 zero mark, 2 proximity switch
// R4: First program rotation after reset synchronises
// R5: Controller request bit resyncs that spindle
// R6: Indirect encoder resyncs after gear change
// R7: Resync once encoder back below cut-off
// R8: Only program commands permit synchronisation
// R9: Proximity source resyncs after gear change
// R10: Stopped flag when speed below tolerance
// R11: Feed enable gated by status when set
// R12: In-setpoint flag within speed tolerance
// R13: Commanded speed clamped to maximum
// R14: Over limit plus tolerance: flag, alarm
// R15: Synced status drops on need, resets
`timescale 1ns/1ps
`default_nettype none
module ssm_top #(
  parameter int POS_W = ssm_pkg::POS_W,
  parameter int SPD_W = ssm_pkg::SPD_W
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_b_i,
  input  wire logic [3:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [31:0]              rdata_o,
  input  wire ssm_pkg::ssm_drive_s drv0_i,
  input  wire ssm_pkg::ssm_drive_s drv1_i,
  input  wire logic [SPD_W-1:0]    act_spd_i,
  output logic [SPD_W-1:0]         spd_cmd_o,
  output logic                     feed_en_o,
  output logic                     stopped_o,
  output logic                     in_setpoint_o,
  output logic                     limit_exc_o,
  output logic                     alarm_o,
  output logic [15:0]              alarm_code_o,
  output logic [1:0]               synced_o,
  output logic                     irq_o
);

  logic [31:0]      ctrl_reg;
  logic [POS_W-1:0] ref_pos_reg;
  logic [POS_W-1:0] zm_ofs_reg;
  logic [SPD_W-1:0] stop_tol_reg;
  logic [SPD_W-1:0] set_tol_reg;
  logic [SPD_W-1:0] max_spd_reg;
  logic [SPD_W-1:0] cmd_spd_reg;
  logic [ssm_pkg::EV_W-1:0] irq_stat_reg;
  logic [ssm_pkg::EV_W-1:0] irq_en_reg;
  logic [ssm_pkg::EV_W-1:0] irq_ev;
  logic [1:0]       resync_req;
  logic [1:0]       sync_evt;
  logic [1:0]       synced;
  logic [POS_W-1:0] pos [2];
  logic [SPD_W-1:0] clamp_spd;
  ssm_pkg::ssm_mon_s mon;
  ssm_pkg::ssm_drive_s drv [2];
  logic             limit_d_reg;

  assign drv[0] = drv0_i;
  assign drv[1] = drv1_i;

  // Control and configuration writes; request bits self-clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg     <= ssm_pkg::CTRL_RST;
      ref_pos_reg  <= '0;
      zm_ofs_reg   <= '0;
      stop_tol_reg <= '0;
      set_tol_reg  <= '0;
      max_spd_reg  <= '1;
      cmd_spd_reg  <= '0;
    end else begin
      ctrl_reg[ssm_pkg::CTRL_RESYNC0] <= 1'b0;
      ctrl_reg[ssm_pkg::CTRL_RESYNC1] <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          ssm_pkg::A_CTRL:     ctrl_reg     <= wdata_i;
          ssm_pkg::A_REF_POS:  ref_pos_reg  <= wdata_i[POS_W-1:0];
          ssm_pkg::A_ZM_OFS:   zm_ofs_reg   <= wdata_i[POS_W-1:0];
          ssm_pkg::A_STOP_TOL: stop_tol_reg <= wdata_i[SPD_W-1:0];
          ssm_pkg::A_SET_TOL:  set_tol_reg  <= wdata_i[SPD_W-1:0];
          ssm_pkg::A_MAX_SPD:  max_spd_reg  <= wdata_i[SPD_W-1:0];
          ssm_pkg::A_CMD_SPD:  cmd_spd_reg  <= wdata_i[SPD_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Per-spindle pin synchronisers, resync causes and sync engines
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sp
      logic [2:0] zm_sr_reg;
      logic [2:0] px_sr_reg;
      logic [2:0] gc_sr_reg;
      logic [2:0] oc_sr_reg;
      logic       zm_reg;
      logic       px_reg;
      logic       gc_reg;
      logic       oc_reg;
      logic       gc_d_reg;
      logic       oc_d_reg;
      logic       need;
      // Three-stage shift; a level counts once stages two and three agree
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          zm_sr_reg <= '0;
          px_sr_reg <= '0;
          gc_sr_reg <= '0;
          oc_sr_reg <= '0;
          zm_reg    <= 1'b0;
          px_reg    <= 1'b0;
          gc_reg    <= 1'b0;
          oc_reg    <= 1'b0;
          gc_d_reg  <= 1'b0;
          oc_d_reg  <= 1'b0;
        end else begin
          zm_sr_reg <= {zm_sr_reg[1:0], drv[g].zero_mark};
          px_sr_reg <= {px_sr_reg[1:0], drv[g].prox_sw};
          gc_sr_reg <= {gc_sr_reg[1:0], drv[g].gear_change};
          oc_sr_reg <= {oc_sr_reg[1:0], drv[g].over_cutoff};
          if (zm_sr_reg[1] == zm_sr_reg[2]) zm_reg <= zm_sr_reg[2];
          if (px_sr_reg[1] == px_sr_reg[2]) px_reg <= px_sr_reg[2];
          if (gc_sr_reg[1] == gc_sr_reg[2]) gc_reg <= gc_sr_reg[2];
          if (oc_sr_reg[1] == oc_sr_reg[2]) oc_reg <= oc_sr_reg[2];
          gc_d_reg  <= gc_reg;
          oc_d_reg  <= oc_reg;
        end
      end
      // Resync need: request bit, gear change end with indirect encoder or proximity source, cut-off end
      assign need = resync_req[g] // [R5]
        | (gc_d_reg & ~gc_reg & ~ctrl_reg[ssm_pkg::CTRL_DIRECT]) // [R6]
        | (gc_d_reg & ~gc_reg
           & (ctrl_reg[ssm_pkg::CTRL_SRC_LSB +: 2] == ssm_pkg::SRC_PROX_SW)) // [R9]
        | (oc_d_reg & ~oc_reg); // [R7]

      ssm_spindle_sync #(.POS_W(POS_W)) u_sync (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .enc_delta_i (drv[g].enc_delta),
        .zero_mark_i (zm_reg),
        .prox_sw_i   (px_reg),
        .prog_cmd_i  (drv[g].prog_cmd), // [R8]
        .need_sync_i (need),
        .src_sel_i   (ctrl_reg[ssm_pkg::CTRL_SRC_LSB +: 2]),
        .ref_pos_i   (ref_pos_reg),
        .zm_ofs_i    (zm_ofs_reg),
        .pos_o       (pos[g]),
        .synced_o    (synced[g]),
        .sync_evt_o  (sync_evt[g])
      );
    end
  endgenerate

  assign resync_req[0] = ctrl_reg[ssm_pkg::CTRL_RESYNC0]; // [R5]
  assign resync_req[1] = ctrl_reg[ssm_pkg::CTRL_RESYNC1]; // [R5]

  ssm_speed_mon #(.SPD_W(SPD_W)) u_mon (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .act_spd_i   (act_spd_i),
    .cmd_spd_i   (cmd_spd_reg),
    .stop_tol_i  (stop_tol_reg),
    .set_tol_i   (set_tol_reg),
    .max_spd_i   (max_spd_reg),
    .clamp_spd_o (clamp_spd),
    .mon_o       (mon)
  );

  // Status outputs, all registered
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spd_cmd_o     <= '0;
      feed_en_o     <= 1'b0;
      stopped_o     <= 1'b0;
      in_setpoint_o <= 1'b0;
      limit_exc_o   <= 1'b0;
      alarm_o       <= 1'b0;
      alarm_code_o  <= '0;
      synced_o      <= '0;
      limit_d_reg   <= 1'b0;
    end else begin
      spd_cmd_o     <= clamp_spd; // [R13]
      feed_en_o     <= ~ctrl_reg[ssm_pkg::CTRL_FEEDEN] | mon.stopped | mon.in_setpoint; // [R11]
      stopped_o     <= mon.stopped; // [R10]
      in_setpoint_o <= mon.in_setpoint; // [R12]
      limit_exc_o   <= mon.limit_exc; // [R14]
      alarm_o       <= mon.limit_exc; // [R14]
      alarm_code_o  <= mon.limit_exc ? ssm_pkg::ALARM_SPEED_LIMIT : 16'h0000; // [R14]
      synced_o      <= synced; // [R15]
      limit_d_reg   <= mon.limit_exc;
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  assign irq_ev = {mon.limit_exc & ~limit_d_reg, sync_evt};
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
      irq_o        <= 1'b0;
    end else begin
      if (wr_i && addr_i == ssm_pkg::A_IRQ_EN) irq_en_reg <= wdata_i[ssm_pkg::EV_W-1:0];
      if (wr_i && addr_i == ssm_pkg::A_IRQ_CLR) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata_i[ssm_pkg::EV_W-1:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq_o <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ssm_pkg::A_CTRL:     rdata_o <= ctrl_reg;
        ssm_pkg::A_REF_POS:  rdata_o <= 32'(ref_pos_reg);
        ssm_pkg::A_ZM_OFS:   rdata_o <= 32'(zm_ofs_reg);
        ssm_pkg::A_STOP_TOL: rdata_o <= 32'(stop_tol_reg);
        ssm_pkg::A_SET_TOL:  rdata_o <= 32'(set_tol_reg);
        ssm_pkg::A_MAX_SPD:  rdata_o <= 32'(max_spd_reg);
        ssm_pkg::A_STATUS:   rdata_o <= {26'h0, feed_en_o, limit_exc_o, in_setpoint_o,
                                         stopped_o, synced_o};
        ssm_pkg::A_IRQ_STAT: rdata_o <= 32'(irq_stat_reg);
        ssm_pkg::A_IRQ_EN:   rdata_o <= 32'(irq_en_reg);
        ssm_pkg::A_POS0:     rdata_o <= 32'(pos[0]);
        ssm_pkg::A_POS1:     rdata_o <= 32'(pos[1]);
        ssm_pkg::A_CMD_SPD:  rdata_o <= 32'(cmd_spd_reg);
        default:             rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: ssm_top_asserts.sv
/*
  Port checker for ssm_top: read answer, alarm, sync cause, resync, feed.
  Assumes it is bound to ssm_top and shares its clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssm_top_asserts (
  input wire logic                mclk_i,
  input wire logic                rst_b_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  input wire ssm_pkg::ssm_drive_s drv0_i,
  input wire ssm_pkg::ssm_drive_s drv1_i,
  input wire logic                feed_en_o,
  input wire logic                stopped_o,
  input wire logic                in_setpoint_o,
  input wire logic                limit_exc_o,
  input wire logic                alarm_o,
  input wire logic [15:0]         alarm_code_o,
  input wire logic [1:0]          synced_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [1:0] hit;
  logic [3:0] gap0_reg;
  logic [3:0] gap1_reg;
  // Pulses count only under a program command
  assign hit = {(drv1_i.zero_mark | drv1_i.prox_sw) & drv1_i.prog_cmd,
                (drv0_i.zero_mark | drv0_i.prox_sw) & drv0_i.prog_cmd};
  // Saturating age of the last pulse; 15 means long ago
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap0_reg <= 4'hF;
      gap1_reg <= 4'hF;
    end else begin
      gap0_reg <= hit[0] ? 4'h0 : gap0_reg + {3'h0, gap0_reg != 4'hF};
      gap1_reg <= hit[1] ? 4'h0 : gap1_reg + {3'h0, gap1_reg != 4'hF};
    end
  end
  sequence s_spin_ok;
    (stopped_o || in_setpoint_o) ##1 (stopped_o || in_setpoint_o);
  endsequence
  sequence s_cut_fall(cut, sync);
    $fell(cut) && sync;
  endsequence
  property p_drop(cut, sync);
    s_cut_fall(cut, sync) |-> ##[1:8] !sync;
  endproperty
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its answer cycle");
  a_alarm_code: assert property (
    alarm_code_o == (alarm_o ? ssm_pkg::ALARM_SPEED_LIMIT : 16'h0))
    else $error("alarm code does not follow alarm");
  // Over the limit band the clamped target is out of reach, so never in setpoint
  a_alarm_flag: assert property (
    (alarm_o == limit_exc_o) && !(limit_exc_o && in_setpoint_o))
    else $error("alarm, limit and setpoint flags disagree");
  a_sync_cause0: assert property ($rose(synced_o[0]) |-> gap0_reg <= 4'hC)
    else $error("spindle 0 synced without pulse");
  a_sync_cause1: assert property ($rose(synced_o[1]) |-> gap1_reg <= 4'hC)
    else $error("spindle 1 synced without pulse");
  a_cutoff_drop0: assert property (p_drop(drv0_i.over_cutoff, synced_o[0]))
    else $error("spindle 0 kept sync after cut-off");
  a_cutoff_drop1: assert property (p_drop(drv1_i.over_cutoff, synced_o[1]))
    else $error("spindle 1 kept sync after cut-off");
  a_feed_gate: assert property (s_spin_ok |-> feed_en_o)
    else $error("feed held off while spindle ok");
endmodule
bind ssm_top ssm_top_asserts u_chk (
  .mclk_i, .rst_b_i, .rd_i, .rdata_o, .drv0_i, .drv1_i, .feed_en_o, .stopped_o,
  .in_setpoint_o, .limit_exc_o, .alarm_o, .alarm_code_o, .synced_o
);
`default_nettype wire

// file: tb_spindle_sync_monitor.sv
/*
  Self-checking bench for ssm_top with a drive model on its spindle side.
  Assumes ssm_pkg, ssm_drive_model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_spindle_sync_monitor;
  logic                mclk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic [3:0]          addr_i = 4'h0;
  logic [31:0]         wdata_i = 32'h0;
  logic                wr_i = 1'b0;
  logic                rd_i = 1'b0;
  logic [31:0]         rdata_o;
  ssm_pkg::ssm_drive_s drv0_i;
  ssm_pkg::ssm_drive_s drv1_i;
  logic [23:0]         act_spd_i;
  logic [23:0]         spd_cmd_o;
  logic [23:0]         err = 24'h0;
  logic [1:0]          prog = 2'h0;
  logic [1:0]          cut = 2'h0;
  logic [5:0]          req = 6'h0;
  logic [1:0]          synced_o;
  logic                feed_en_o;
  logic                stopped_o;
  logic                in_setpoint_o;
  logic                limit_exc_o;
  logic                alarm_o;
  logic [15:0]         alarm_code_o;
  logic                irq_o;
  logic [31:0]         d;
  int                  n_errors = 0;
  int                  samples_checked = 0;
  int                  cyc = 0;
  ssm_top dut (
    .mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .drv0_i, .drv1_i,
    .act_spd_i, .spd_cmd_o, .feed_en_o, .stopped_o, .in_setpoint_o, .limit_exc_o,
    .alarm_o, .alarm_code_o, .synced_o, .irq_o
  );
  ssm_drive_model u_drv (
    .mclk_i, .rst_b_i, .spd_cmd_i(spd_cmd_o), .spd_err_i(err), .prog_i(prog),
    .req_i(req), .cut_i(cut), .drv0_o(drv0_i), .drv1_o(drv1_i), .act_spd_o(act_spd_i)
  );
  // 125 MHz clock
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  // Ceiling far above the few hundred cycles the tests need
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Idle edge after each strobe so no signal is assigned twice in a step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    v = rdata_o;
  endtask
  // Pin pulses from the drive, then time for sync to settle
  task automatic kick(input logic [5:0] m);
    req <= m;
    @(posedge mclk_i);
    req <= 6'h0;
    repeat (16) @(posedge mclk_i);
  endtask
  task automatic t_regs();
    rd_reg(ssm_pkg::A_CTRL, d);
    chk(d, 32'h1);
    rd_reg(ssm_pkg::A_MAX_SPD, d);
    chk(d & 32'hFF_FFFF, 32'hFF_FFFF);
    rd_reg(4'hD, d);
    chk(d, 32'h0);
    rd_reg(ssm_pkg::A_IRQ_CLR, d);
    chk(d, 32'h0);
    chk(32'(synced_o), 32'h0);
    $display("reset values done");
  endtask
  task automatic t_sync(input int k, input logic [1:0] src);
    logic [5:0] m;
    m = (src == 2'h1) ? (6'h1 << k) : (6'h4 << k);
    wr_reg(ssm_pkg::A_CTRL, {30'h0, src});
    wr_reg(ssm_pkg::A_REF_POS, 32'h1000 + 32'(k));
    wr_reg(ssm_pkg::A_ZM_OFS, 32'h20);
    wr_reg(ssm_pkg::A_IRQ_EN, 32'h7);
    prog <= 2'h0;
    kick(m);
    chk(32'(synced_o[k]), 32'h0);
    prog <= 2'h3;
    kick(m ^ (6'h5 << k));
    chk(32'(synced_o[k]), 32'h0);
    kick(m);
    chk(32'(synced_o[k]), 32'h1);
    rd_reg(ssm_pkg::A_POS0 + 4'(k), d);
    chk(d, 32'h1020 + 32'(k));
    rd_reg(ssm_pkg::A_IRQ_STAT, d);
    chk(d, 32'h1 << k);
    chk(32'(irq_o), 32'h1);
    wr_reg(ssm_pkg::A_IRQ_CLR, 32'h7);
    rd_reg(ssm_pkg::A_IRQ_STAT, d);
    chk(d, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("sync spindle %0d done", k);
  endtask
  task automatic t_drop(input logic [31:0] c, input logic [5:0] md, input logic [5:0] ms,
                        input logic e, input int k);
    wr_reg(ssm_pkg::A_CTRL, c);
    kick(md);
    chk(32'(synced_o[k]), 32'(e));
    kick(ms);
    chk(32'(synced_o[k]), 32'h1);
  endtask
  task automatic t_resync();
    wr_reg(ssm_pkg::A_IRQ_EN, 32'h0);
    t_drop(32'h11, 6'h0, 6'h1, 1'b0, 0);
    t_drop(32'h21, 6'h0, 6'h2, 1'b0, 1);
    chk(32'(irq_o), 32'h0);
    wr_reg(ssm_pkg::A_IRQ_EN, 32'h3);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h1);
    wr_reg(ssm_pkg::A_IRQ_CLR, 32'h3);
    repeat (2) @(posedge mclk_i);
    chk(32'(irq_o), 32'h0);
    $display("resync request done");
  endtask
  task automatic t_gear();
    t_drop(32'h5, 6'h10, 6'h1, 1'b1, 0);
    t_drop(32'h1, 6'h10, 6'h1, 1'b0, 0);
    t_drop(32'h6, 6'h10, 6'h4, 1'b0, 0);
    $display("gear change done");
  endtask
  task automatic t_cutoff();
    wr_reg(ssm_pkg::A_CTRL, 32'h1);
    cut <= 2'h3;
    repeat (8) @(posedge mclk_i);
    cut <= 2'h0;
    kick(6'h0);
    chk(32'(synced_o), 32'h0);
    kick(6'h3);
    chk(32'(synced_o), 32'h3);
    $display("cut-off done");
  endtask
  // Rows: command, drive error, expected {limit, in setpoint, stopped}
  task automatic t_speed();
    logic [51:0] tab [5];
    tab = '{52'h000800_000000_2, 52'h001000_000008_2, 52'h001000_000009_4,
            52'h000000_00000F_1, 52'h000000_000010_0};
    chk(32'(feed_en_o), 32'h1);
    wr_reg(ssm_pkg::A_STOP_TOL, 32'h10);
    wr_reg(ssm_pkg::A_SET_TOL, 32'h8);
    wr_reg(ssm_pkg::A_MAX_SPD, 32'h1000);
    wr_reg(ssm_pkg::A_CMD_SPD, 32'h2000);
    repeat (4) @(posedge mclk_i);
    chk(32'(spd_cmd_o), 32'h1000);
    for (int i = 0; i < 5; i++) begin
      wr_reg(ssm_pkg::A_CMD_SPD, 32'(tab[i][51:28]));
      err <= tab[i][27:4];
      repeat (8) @(posedge mclk_i);
      chk(32'(spd_cmd_o), 32'(tab[i][51:28]));
      chk(32'({limit_exc_o, in_setpoint_o, stopped_o}), 32'(tab[i][3:0]));
      d = tab[i][2] ? {15'h0, 1'b1, ssm_pkg::ALARM_SPEED_LIMIT} : 32'h0;
      chk({15'h0, alarm_o, alarm_code_o}, d);
    end
    rd_reg(ssm_pkg::A_IRQ_STAT, d);
    chk(d & 32'h4, 32'h4);
    wr_reg(ssm_pkg::A_CTRL, 32'h9);
    repeat (4) @(posedge mclk_i);
    chk(32'(feed_en_o), 32'h0);
    err <= 24'h0;
    repeat (8) @(posedge mclk_i);
    chk(32'(feed_en_o), 32'h1);
    // Status word: feed, limit, setpoint, stopped, both spindles synced
    rd_reg(ssm_pkg::A_STATUS, d);
    chk(d, 32'h2F);
    $display("speed monitor done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_sync(0, 2'h1);
    t_sync(1, 2'h2);
    t_resync();
    t_gear();
    t_cutoff();
    t_speed();
    end_of_test();
  end
endmodule
`default_nettype wire
